// ---- common/dcd_regs.vh ----
`ifndef DCD_REGS_VH
`define DCD_REGS_VH

// Datapath width and channel count, 14-bit 16-channel variant
`define DCD_WIDTH_DEFAULT 14
`define DCD_CHANNELS_DEFAULT 16
`define DCD_ADDR_BITS_DEFAULT 4

// Register-select field encodings
`define DCD_SEL_INPUT 2'b11
`define DCD_SEL_OFFSET 2'b10
`define DCD_SEL_GAIN 2'b01
`define DCD_SEL_SPECIAL 2'b00

// Reset values per variant
`define DCD_GAIN_RST_14 14'h3ffe
`define DCD_GAIN_RST_12 12'hffe
`define DCD_OFFSET_RST_14 14'h2000
`define DCD_OFFSET_RST_12 12'h800

// Sequencer states
`define DCD_ST_IDLE 2'h0
`define DCD_ST_READ 2'h1
`define DCD_ST_CALC 2'h2

`endif

// ---- rtl/dcd_coef_mem.v ----
`timescale 1ns/1ps
`include "dcd_regs.vh"

// Per-channel input code, offset and gain store with registered read
module dcd_coef_mem #(
    parameter W = `DCD_WIDTH_DEFAULT,
    parameter CH = `DCD_CHANNELS_DEFAULT,
    parameter AW = `DCD_ADDR_BITS_DEFAULT
) (
    input wire clk_sys,
    input wire nrst,
    input wire wr_en,
    input wire [1:0] wr_sel,
    input wire [AW-1:0] wr_addr,
    input wire [W-1:0] wr_data,
    input wire rd_en,
    input wire [AW-1:0] rd_addr,
    output reg [W-1:0] rd_code_q,
    output reg [W-1:0] rd_gain_q,
    output reg [W-1:0] rd_offset_q
);
    localparam [W-1:0] GAIN_RST = {{(W-1){1'b1}}, 1'b0};
    localparam [W-1:0] OFFSET_RST = {1'b1, {(W-1){1'b0}}};

    reg [W-1:0] code_mem [0:CH-1];
    reg [W-1:0] gain_mem [0:CH-1];
    reg [W-1:0] offset_mem [0:CH-1];
    integer i;

    always @(posedge clk_sys) begin
        if (!nrst) begin
            for (i = 0; i < CH; i = i + 1) begin
                code_mem[i] <= {W{1'b0}};
                gain_mem[i] <= GAIN_RST;
                offset_mem[i] <= OFFSET_RST;
            end
        end else if (wr_en) begin
            case (wr_sel)
                `DCD_SEL_INPUT: code_mem[wr_addr] <= wr_data;
                `DCD_SEL_OFFSET: offset_mem[wr_addr] <= wr_data;
                `DCD_SEL_GAIN: begin
                    gain_mem[wr_addr] <= {wr_data[W-1:1], 1'b0};
                end
                default: ;
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            rd_code_q <= {W{1'b0}};
            rd_gain_q <= GAIN_RST;
            rd_offset_q <= OFFSET_RST;
        end else if (rd_en) begin
            rd_code_q <= code_mem[rd_addr];
            rd_gain_q <= gain_mem[rd_addr];
            rd_offset_q <= offset_mem[rd_addr];
        end
    end
endmodule

// ---- rtl/dcd_channel_decode.v ----
`timescale 1ns/1ps
`include "dcd_regs.vh"

module dcd_channel_decode #(
    parameter W = `DCD_WIDTH_DEFAULT,
    parameter CH = `DCD_CHANNELS_DEFAULT,
    parameter AW = `DCD_ADDR_BITS_DEFAULT
) (
    input wire clk_sys,
    input wire nrst,
    input wire interface_select,
    input wire frame_select_n,
    input wire word_strobe,
    input wire [AW-1:0] channel_address,
    input wire register_select_high,
    input wire register_select_low,
    input wire [W-1:0] data_field,
    input wire load_all_channels_strobe,
    output reg spi_mode_q,
    output reg serial_active_q,
    output reg busy_q,
    output reg sfr_write_q,
    output reg [AW-1:0] sfr_address_q,
    output reg [W-1:0] sfr_data_q,
    output reg [CH*W-1:0] corrected_code_q
);
    localparam [W-1:0] ONES = {W{1'b1}};
    localparam [2*W+1:0] TWO = {{(2*W+1){1'b0}}, 1'b1} << 1;
    localparam signed [W+3:0] HALF = {4'h0, 1'b1, {(W-1){1'b0}}};
    localparam signed [W+3:0] MAXS = {4'h0, {W{1'b1}}};

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [AW-1:0] pend_q;
    reg frame_prev_q;
    reg [CH*W-1:0] hold_q;

    wire [1:0] reg_sel = {register_select_high, register_select_low};
    wire [W-1:0] mem_code;
    wire [W-1:0] mem_gain;
    wire [W-1:0] mem_offset;
    wire word_take;
    wire coef_write;

    // Corrected code: product truncated, offset applied, then clamped
    function [W-1:0] dcd_correct;
        input [W-1:0] code;
        input [W-1:0] gain;
        input [W-1:0] offs;
        reg [2*W+1:0] prod;
        reg signed [W+3:0] sum;
        begin
            prod = {{(W+2){1'b0}}, code} * ({{(W+2){1'b0}}, gain} + TWO);
            sum = $signed({3'b000, prod[2*W:W]}) + $signed({4'h0, offs})
                - HALF;
            if (sum < 0)
                dcd_correct = {W{1'b0}};
            else if (sum > MAXS)
                dcd_correct = ONES;
            else
                dcd_correct = sum[W-1:0];
        end
    endfunction

    // Words are taken only while awake (or in non-SPI mode) and no recompute is pending
    assign word_take = word_strobe && state_q == `DCD_ST_IDLE &&
        (serial_active_q || !spi_mode_q);
    assign coef_write = word_take && reg_sel != `DCD_SEL_SPECIAL;

    dcd_coef_mem #(
        .W(W),
        .CH(CH),
        .AW(AW)
    ) u_mem (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .wr_en(coef_write),
        .wr_sel(reg_sel),
        .wr_addr(channel_address),
        .wr_data(data_field),
        .rd_en(state_q == `DCD_ST_READ),
        .rd_addr(pend_q),
        .rd_code_q(mem_code),
        .rd_gain_q(mem_gain),
        .rd_offset_q(mem_offset)
    );

    always @* begin
        state_d = state_q;
        case (state_q)
            `DCD_ST_IDLE: begin
                if (coef_write)
                    state_d = `DCD_ST_READ;
            end
            `DCD_ST_READ: state_d = `DCD_ST_CALC;
            `DCD_ST_CALC: state_d = `DCD_ST_IDLE;
            default: state_d = `DCD_ST_IDLE;
        endcase
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            state_q <= `DCD_ST_IDLE;
            pend_q <= {AW{1'b0}};
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q <= state_d != `DCD_ST_IDLE;
            if (coef_write)
                pend_q <= channel_address;
        end
    end

    // Mode pin and frame-select wake-up
    always @(posedge clk_sys) begin
        if (!nrst) begin
            spi_mode_q <= 1'b1;
            frame_prev_q <= 1'b1;
            serial_active_q <= 1'b0;
        end else begin
            spi_mode_q <= interface_select;
            frame_prev_q <= frame_select_n;
            if (frame_prev_q && !frame_select_n)
                serial_active_q <= 1'b1;
            else if (frame_select_n)
                serial_active_q <= 1'b0;
        end
    end

    // Special function words are passed out for the control logic
    always @(posedge clk_sys) begin
        if (!nrst) begin
            sfr_write_q <= 1'b0;
            sfr_address_q <= {AW{1'b0}};
            sfr_data_q <= {W{1'b0}};
        end else begin
            sfr_write_q <= word_take && reg_sel == `DCD_SEL_SPECIAL;
            if (word_take && reg_sel == `DCD_SEL_SPECIAL) begin
                sfr_address_q <= channel_address;
                sfr_data_q <= data_field;
            end
        end
    end

    // Holding stage per channel, converter registers load together
    always @(posedge clk_sys) begin
        if (!nrst) begin
            hold_q <= {(CH*W){1'b0}};
            corrected_code_q <= {(CH*W){1'b0}};
        end else begin
            if (state_q == `DCD_ST_CALC)
                hold_q[pend_q*W +: W] <=
                    dcd_correct(mem_code, mem_gain, mem_offset);
            if (load_all_channels_strobe)
                corrected_code_q <= hold_q;
        end
    end
endmodule

// ---- bench/dcd_channel_decode_asserts.sv ----
`timescale 1ns/1ps
module dcd_channel_decode_asserts #(
    parameter W = 14,
    parameter CH = 16,
    parameter AW = 4
) (
    input wire clk_sys,
    input wire nrst,
    input wire interface_select,
    input wire frame_select_n,
    input wire word_strobe,
    input wire [AW-1:0] channel_address,
    input wire register_select_high,
    input wire register_select_low,
    input wire [W-1:0] data_field,
    input wire load_all_channels_strobe,
    input wire spi_mode_q,
    input wire serial_active_q,
    input wire busy_q,
    input wire sfr_write_q,
    input wire [AW-1:0] sfr_address_q,
    input wire [W-1:0] sfr_data_q,
    input wire [CH*W-1:0] corrected_code_q
);
    wire take = word_strobe && !busy_q && (serial_active_q || !spi_mode_q);
    wire sfr_w = take && !register_select_high && !register_select_low;
    wire coef_w = take && (register_select_high || register_select_low);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    mode_copy_a: assert property ($past(nrst) |-> spi_mode_q ==
        $past(interface_select)) else $error("mode copy wrong");
    wake_fall_a: assert property ($fell(frame_select_n) |=>
        serial_active_q) else $error("no wake on frame fall");
    sleep_high_a: assert property (frame_select_n |=>
        !serial_active_q) else $error("awake with frame high");
    sfr_copy_a: assert property (sfr_w |=> sfr_write_q &&
        sfr_address_q == $past(channel_address) &&
        sfr_data_q == $past(data_field)) else $error("special word lost");
    sfr_cause_a: assert property (sfr_write_q |->
        $past(sfr_w)) else $error("spurious special pulse");
    coef_busy_a: assert property (coef_w |=> busy_q && !sfr_write_q
        ##1 busy_q ##1 !busy_q) else $error("recompute timing wrong");
    asleep_drop_a: assert property (word_strobe && spi_mode_q &&
        !serial_active_q && !busy_q |=> !busy_q && !sfr_write_q)
        else $error("word taken while asleep");
    out_hold_a: assert property (!load_all_channels_strobe |=>
        $stable(corrected_code_q)) else $error("output moved without load");
    cover property (sfr_w);
    cover property (coef_w && register_select_high && register_select_low);
    cover property (load_all_channels_strobe);
endmodule

// ---- bench/dcd_host_model.sv ----
`timescale 1ns/1ps
module dcd_host_model (
    input wire clk_sys,
    output reg frame_select_n,
    output reg word_strobe,
    output reg [3:0] channel_address,
    output reg register_select_high,
    output reg register_select_low,
    output reg [13:0] data_field
);
    initial begin
        frame_select_n = 1;
        word_strobe = 0;
        channel_address = 4'h0;
        {register_select_high, register_select_low} = 2'h0;
        data_field = 14'h0;
    end
    // One word per frame; wk low skips the wake edge
    task put(input [3:0] a, input [1:0] s, input [13:0] d, input wk);
        begin
            @(posedge clk_sys);
            #1 frame_select_n = !wk;
            @(posedge clk_sys);
            #1 word_strobe = 1;
            channel_address = a;
            {register_select_high, register_select_low} = s;
            data_field = d;
            @(posedge clk_sys);
            #1 word_strobe = 0;
            channel_address = ~a;
            data_field = ~d;
            repeat (3) @(posedge clk_sys);
            #1 frame_select_n = 1;
        end
    endtask
endmodule

// ---- bench/dcd_channel_decode_tb_top.sv ----
`timescale 1ns/1ps
`include "dcd_regs.vh"
module dcd_channel_decode_tb_top;
    logic clk_sys, nrst, interface_select, ld;
    wire frame_select_n, word_strobe, rsh, rsl, spi_q, act_q, busy_q, sfr_q;
    wire [3:0] ch_a, sfr_a;
    wire [13:0] dat, sfr_d;
    wire [223:0] cc_q;
    integer err_total = 0, checks = 0, i;
    logic [3:0] rch [0:4] = '{4'h0, 4'h5, 4'hf, 4'h3, 4'h7};
    logic [13:0] rx [0:4] = '{14'h2000, 14'h3fff, 14'h3fff, 14'h10, 14'h1000};
    logic [13:0] rm [0:4] = '{14'h3ffe, 14'h2fff, 14'h3ffe, 14'h3ffe, 14'h1ffe};
    logic [13:0] rc [0:4] = '{14'h2000, 14'h2000, 14'h3fff, 14'h0, 14'h2001};
    logic [13:0] re [0:4] = '{14'h2000, 14'h2fff, 14'h3fff, 14'h0, 14'h801};
    dcd_host_model dcd_host_model_i (.clk_sys(clk_sys),
        .frame_select_n(frame_select_n), .word_strobe(word_strobe),
        .channel_address(ch_a), .register_select_high(rsh),
        .register_select_low(rsl), .data_field(dat));
    dcd_channel_decode #(.W(14), .CH(16), .AW(4)) dcd_channel_decode_i (
        .clk_sys(clk_sys), .nrst(nrst), .interface_select(interface_select),
        .frame_select_n(frame_select_n), .word_strobe(word_strobe),
        .channel_address(ch_a), .register_select_high(rsh),
        .register_select_low(rsl), .data_field(dat),
        .load_all_channels_strobe(ld), .spi_mode_q(spi_q),
        .serial_active_q(act_q), .busy_q(busy_q), .sfr_write_q(sfr_q),
        .sfr_address_q(sfr_a), .sfr_data_q(sfr_d), .corrected_code_q(cc_q));
    task chk(input string nm, input logic [13:0] seen, input logic [13:0] ex);
        checks++;
        if (seen !== ex) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, ex, seen);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task load;
        @(posedge clk_sys);
        #1 ld = 1;
        @(posedge clk_sys);
        #1 ld = 0;
    endtask
    initial begin
        clk_sys = 0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        #200000 err_total++;
        close_out;
    end
    initial begin
        nrst = 0;
        interface_select = 1;
        ld = 0;
        repeat (20) @(posedge clk_sys);
        #1 nrst = 1;
        chk("mode", {13'h0, spi_q}, 14'h1);
        for (i = 0; i < 5; i++) begin
            dcd_host_model_i.put(rch[i], `DCD_SEL_INPUT, rx[i], 1);
            dcd_host_model_i.put(rch[i], `DCD_SEL_GAIN, rm[i], 1);
            dcd_host_model_i.put(rch[i], `DCD_SEL_OFFSET, rc[i], 1);
            chk("held", cc_q[rch[i]*14 +: 14], 14'h0);
            load;
            chk("code", cc_q[rch[i]*14 +: 14], re[i]);
        end
        dcd_host_model_i.put(4'h9, `DCD_SEL_INPUT, 14'h1234, 1);
        load;
        chk("dflt", cc_q[126 +: 14], 14'h1234);
        dcd_host_model_i.put(4'h9, `DCD_SEL_INPUT, 14'h0, 0);
        load;
        chk("sleep", cc_q[126 +: 14], 14'h1234);
        dcd_host_model_i.put(4'h2, `DCD_SEL_SPECIAL, 14'h1abc, 1);
        chk("sfr", sfr_d, 14'h1abc);
        chk("sfra", {10'h0, sfr_a}, 14'h2);
        interface_select = 0;
        dcd_host_model_i.put(4'h9, `DCD_SEL_INPUT, 14'h100, 0);
        load;
        chk("i2c", cc_q[126 +: 14], 14'h100);
        nrst = 0;
        repeat (2) @(posedge clk_sys);
        #1 nrst = 1;
        chk("rst", cc_q[126 +: 14], 14'h0);
        dcd_host_model_i.put(4'h9, `DCD_SEL_INPUT, 14'h2abc, 0);
        load;
        chk("rdef", cc_q[126 +: 14], 14'h2abc);
        close_out;
    end
endmodule
bind dcd_channel_decode dcd_channel_decode_asserts #(.W(W), .CH(CH), .AW(AW))
    dcd_channel_decode_asserts_i (.*);
